// File: logic/aso_serial_out.sv
/*
 * Serial output side of a 16-bit converter: clipping, range flag, word FIFO,
 * master-clock framing, sync and power-down handling.
 * Assumes the master clock, sync and power-down pins are asynchronous to
 * CLOCK_I and that the master clock runs well below a quarter of CLOCK_I.
 */
`timescale 1ns/10ps

module aso_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic             enable_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wptr;
    logic [PW-1:0]    rptr;
    logic [PW:0]      count;
    logic [PW-1:0]    next_wptr;
    logic [PW-1:0]    next_rptr;
    logic [PW:0]      next_count;
    logic             next_in_ready;
    logic             push;
    logic             pop;

    // Ready is registered and looks one cycle ahead, so the source is
    // throttled honestly while the port itself stays a flip-flop.
    always_comb begin
        push          = in_valid_i && in_ready_o;
        pop           = out_ready_i && out_valid_o;
        next_wptr     = push ? PW'(wptr + 1'b1) : wptr;
        next_rptr     = pop ? PW'(rptr + 1'b1) : rptr;
        next_count    = (PW+1)'(count + (PW+1)'(push) - (PW+1)'(pop));
        next_in_ready = enable_i && (next_count != (PW+1)'(DEPTH));
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wptr       <= '0;
            rptr       <= '0;
            count      <= '0;
            in_ready_o <= 1'b0;
        end else begin
            wptr       <= next_wptr;
            rptr       <= next_rptr;
            count      <= next_count;
            in_ready_o <= next_in_ready;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wptr] <= in_data_i;
        end
    end

    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rptr];
endmodule

module aso_serial_out (
    input  wire logic                          CLOCK_I,
    input  wire logic                          RESETN_I,
    input  wire logic                          MASTER_CLK_I,
    input  wire logic                          SYNC_I,
    input  wire logic                          POWER_DOWN_N_I,
    input  wire logic                          SAMPLE_VALID_I,
    input  wire logic signed [aso_pkg::RAW_BITS-1:0] SAMPLE_DATA_I,
    output logic                               SAMPLE_READY_O,
    output aso_pkg::aso_serial_s               SERIAL_O,
    output aso_pkg::aso_serial_s               SERIAL_N_O,
    output logic                               RANGE_ERROR_FLAG_O,
    output logic                               INITIALISED_O
);
    import aso_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] mclk_sync;
    logic [1:0] sync_sync;
    logic [1:0] pd_sync;
    logic       mclk_prev;

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            mclk_sync <= 2'h0;
            sync_sync <= 2'h0;
            pd_sync   <= 2'h0;
            mclk_prev <= 1'b0;
        end else begin
            mclk_sync <= {mclk_sync[0], MASTER_CLK_I};
            sync_sync <= {sync_sync[0], SYNC_I};
            pd_sync   <= {pd_sync[0], POWER_DOWN_N_I};
            mclk_prev <= mclk_sync[1];
        end
    end

    logic mclk_rise;
    logic mclk_fall;
    logic sync_hi;
    logic awake;
    assign mclk_rise = mclk_sync[1] && !mclk_prev;
    assign mclk_fall = !mclk_sync[1] && mclk_prev;
    assign sync_hi   = sync_sync[1];
    assign awake     = pd_sync[1];

    // ------------------------------------------------------------------
    // Clipping and word FIFO
    // ------------------------------------------------------------------
    aso_word_s in_word;
    aso_word_s out_word;
    logic      fifo_out_valid;
    logic      fifo_pop;

    always_comb begin
        if (SAMPLE_DATA_I > RAW_BITS'(signed'(CODE_POS_MAX))) begin
            in_word = '{range_err: 1'b1, code: CODE_POS_MAX};
        end else if (SAMPLE_DATA_I < RAW_BITS'(signed'(CODE_NEG_MIN))) begin
            in_word = '{range_err: 1'b1, code: CODE_NEG_MIN};
        end else begin
            in_word = '{range_err: 1'b0, code: SAMPLE_DATA_I[WORD_BITS-1:0]};
        end
    end

    // Conversion stops in power-down: the FIFO refuses samples.
    aso_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (CLOCK_I),
        .resetn_i    (RESETN_I),
        .enable_i    (awake),
        .in_valid_i  (SAMPLE_VALID_I),
        .in_ready_o  (SAMPLE_READY_O),
        .in_data_i   (in_word),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (out_word)
    );

    // ------------------------------------------------------------------
    // Framing state
    // ------------------------------------------------------------------
    aso_state_e             state;
    aso_state_e             next_state;
    logic [BIT_CNT_BITS-1:0] bit_cnt;
    logic [BIT_CNT_BITS-1:0] next_bit_cnt;
    logic [5:0]             settle_cnt;
    logic [5:0]             next_settle_cnt;
    logic [WORD_BITS-1:0]   shift;
    logic [WORD_BITS-1:0]   next_shift;
    logic                   pend_err;
    logic                   next_pend_err;
    logic                   err_due;
    logic                   next_err_due;
    logic                   range_err;
    logic                   next_range_err;
    logic                   inited;
    logic                   next_inited;
    aso_serial_s            ser;
    aso_serial_s            next_ser;

    always_comb begin
        next_state      = state;
        next_bit_cnt    = bit_cnt;
        next_settle_cnt = settle_cnt;
        next_shift      = shift;
        next_pend_err   = pend_err;
        next_err_due    = err_due;
        next_range_err  = range_err;
        next_inited     = inited;
        next_ser        = ser;
        fifo_pop        = 1'b0;
        next_ser.bit_clock = awake && mclk_sync[1];
        if (!awake) begin
            next_ser = '0;
        end else if (sync_hi) begin
            next_state      = ST_SYNC;
            next_bit_cnt    = BIT_FIRST;
            next_settle_cnt = SETTLE_RST;
            next_ser.frame_sync_out = 1'b0;
            next_ser.data   = 1'b0;
        end else begin
            unique case (state)
                ST_UNINIT: begin
                    next_ser.frame_sync_out = 1'b0;
                end
                ST_SYNC: begin
                    next_state  = ST_SETTLE;
                    next_inited = 1'b1;
                end
                ST_SETTLE, ST_RUN: begin
                    if (mclk_rise) begin
                        next_bit_cnt = BIT_CNT_BITS'(bit_cnt + 1'b1);
                        next_ser.frame_sync_out = 1'b0;
                        next_ser.data = shift[WORD_BITS-1];
                        next_shift    = {shift[WORD_BITS-2:0], 1'b0};
                        if (bit_cnt == BIT_FIRST && state == ST_SETTLE) begin
                            next_settle_cnt = 6'(settle_cnt + 1'b1);
                            if (settle_cnt == SETTLE_LAST) begin
                                next_state = ST_RUN;
                            end
                        end else if (bit_cnt == BIT_FIRST && fifo_out_valid) begin
                            fifo_pop      = 1'b1;
                            next_ser.frame_sync_out = 1'b1;
                            next_ser.data = out_word.code[WORD_BITS-1];
                            next_shift    = {out_word.code[WORD_BITS-2:0], 1'b0};
                            next_pend_err = out_word.range_err;
                            next_err_due  = 1'b1;
                        end
                    end
                    if (mclk_fall && err_due) begin
                        next_range_err = pend_err;
                        next_err_due   = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state      <= ST_UNINIT;
            bit_cnt    <= BIT_FIRST;
            settle_cnt <= SETTLE_RST;
            shift      <= '0;
            pend_err   <= 1'b0;
            err_due    <= 1'b0;
            range_err  <= 1'b0;
            inited     <= 1'b0;
            ser        <= '0;
            SERIAL_N_O <= '1;
        end else begin
            state      <= next_state;
            bit_cnt    <= next_bit_cnt;
            settle_cnt <= next_settle_cnt;
            shift      <= next_shift;
            pend_err   <= next_pend_err;
            err_due    <= next_err_due;
            range_err  <= next_range_err;
            inited     <= next_inited;
            ser        <= next_ser;
            SERIAL_N_O <= ~next_ser;
        end
    end

    assign SERIAL_O           = ser;
    assign RANGE_ERROR_FLAG_O = range_err;
    assign INITIALISED_O      = inited;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_err_rise;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        $rose(range_err) |-> $past(mclk_fall) && $past(pend_err);
    endproperty
    a_err_rise: assert property (p_err_rise) else $error("range flag rose off a fall edge");

    property p_err_fall;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        $fell(range_err) && awake && $past(awake) |-> $past(mclk_fall) && !$past(pend_err);
    endproperty
    a_err_fall: assert property (p_err_fall) else $error("range flag fell off a fall edge");

    property p_inverted;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        SERIAL_N_O == ~ser;
    endproperty
    a_inverted: assert property (p_inverted) else $error("complement outputs disagree");

    property p_settle_quiet;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        state != ST_RUN |-> !ser.frame_sync_out;
    endproperty
    a_settle_quiet: assert property (p_settle_quiet) else $error("frame sync before settle");

    property p_settle_count;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        state == ST_SETTLE && next_state == ST_RUN |-> settle_cnt == SETTLE_LAST;
    endproperty
    a_settle_count: assert property (p_settle_count) else $error("settle count is wrong");

    property p_pd_quiet;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        !awake |=> ser == '0 && !SAMPLE_READY_O;
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("activity in power-down");

    // Power-down freezes the framing state, so no new sync is needed on exit.
    property p_pd_keeps_init;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        !awake |=> state == $past(state) && inited == $past(inited)
            && bit_cnt == $past(bit_cnt);
    endproperty
    a_pd_keeps_init: assert property (p_pd_keeps_init) else $error("initialised state lost");

    property p_sync_quiet;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        sync_hi ##1 sync_hi |-> !ser.frame_sync_out && !ser.data;
    endproperty
    a_sync_quiet: assert property (p_sync_quiet) else $error("transfer while sync high");

    property p_frame_slot;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        $rose(ser.frame_sync_out) |-> $past(mclk_rise) && $past(bit_cnt) == BIT_FIRST;
    endproperty
    a_frame_slot: assert property (p_frame_slot) else $error("frame sync outside slot");

    property p_msb_first;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        fifo_pop |=> ser.data == $past(out_word.code[WORD_BITS-1]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first bit is not the MSB");

    property p_clip;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        SAMPLE_DATA_I > RAW_BITS'(signed'(CODE_POS_MAX)) |-> in_word.code == CODE_POS_MAX;
    endproperty
    a_clip: assert property (p_clip) else $error("positive clip is wrong");
endmodule

// File: logic/aso_pkg.sv
/*
 * Shared constants and carrier types for the converter serial output block.
 * Assumes one system clock at 100 MHz and a sampled master clock from outside.
 */
package aso_pkg;

    // ------------------------------------------------------------------
    // Word format and framing
    // ------------------------------------------------------------------
    localparam int          WORD_BITS    = 16;
    localparam int          RAW_BITS     = 18;
    localparam int          BIT_CNT_BITS = 4;
    localparam int          FIFO_DEPTH   = 16;
    localparam logic [15:0] CODE_POS_MAX = 16'h7FFF;
    localparam logic [15:0] CODE_NEG_MIN = 16'h8000;
    localparam logic [3:0]  BIT_FIRST    = 4'h0;

    // ------------------------------------------------------------------
    // Filter settling after a sync, in conversion periods
    // ------------------------------------------------------------------
    localparam int          SETTLE_CONV  = 51;
    localparam logic [5:0]  SETTLE_LAST  = 6'(SETTLE_CONV - 1);
    localparam logic [5:0]  SETTLE_RST   = 6'h00;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                 range_err;
        logic [WORD_BITS-1:0] code;
    } aso_word_s;

    localparam int WORD_W = $bits(aso_word_s);

    typedef struct packed {
        logic frame_sync_out;
        logic bit_clock;
        logic data;
    } aso_serial_s;

    typedef enum logic [1:0] {
        ST_UNINIT,
        ST_SYNC,
        ST_SETTLE,
        ST_RUN
    } aso_state_e;

endpackage

// File: dv/aso_rx_model.sv
/*
 * Host serial receiver model: captures frames on the device bit clock.
 * Assumes the device drives frame sync, bit clock and data plus their inverses.
 */
`timescale 1ns/10ps
module aso_rx_model (
    input  wire aso_pkg::aso_serial_s serial_i,
    input  wire aso_pkg::aso_serial_s serial_n_i,
    input  wire logic                 range_flag_i,
    output logic [15:0]               word_o,
    output logic                      flag_o,
    output int                        frames_o,
    output int                        errs_o
);
    import aso_pkg::*;
    logic [15:0] shift;
    int          bits;
    initial begin
        word_o = 16'h0000;
        flag_o = 1'b0;
        frames_o = 0;
        errs_o = 0;
        bits = 0;
    end
    // ------------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------------
    // The receiver only listens, and samples half a bit after data moves.
    // A short settle after the edge keeps the two copies from racing each other.
    always @(negedge serial_i.bit_clock) begin
        #1;
        if (serial_n_i !== ~serial_i) errs_o++;
        if (serial_i.frame_sync_out === 1'b1) begin
            if (bits != 0) errs_o++;
            bits = 1;
            shift = {15'h0000, serial_i.data};
        end else if (bits != 0) begin
            bits++;
            shift = {shift[14:0], serial_i.data};
            if (bits == 2) flag_o = range_flag_i;
            if (bits == 16) begin
                word_o = shift;
                bits = 0;
                frames_o++;
            end
        end
    end
endmodule

// File: dv/aso_serial_out_test.sv
/*
 * Self-checking bench for the converter serial output block.
 * Assumes the receiver model in this folder and a master clock that the bench stops during power-down.
 */
`timescale 1ns/10ps
module aso_serial_out_test;
    import aso_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, mclk = 1'b0, sync = 1'b0, pd_n = 1'b1;
    logic s_valid = 1'b0, s_ready, flag, init, rx_flag, mclk_run = 1'b1;
    logic signed [RAW_BITS-1:0] s_data = '0;
    aso_serial_s ser, ser_n;
    logic [15:0] rx_word;
    int rx_frames, rx_errs, mrise = 0, brise = 0, n_mismatch = 0, n_compared = 0;
    logic [16:0] exp_q[$], got_q[$];
    int mark_q[$];
    int raw_tab[7] = '{40000, 32767, 1, -1, -32768, -40000, 0};

    always #5 clk = ~clk;
    always #62.5 if (mclk_run) mclk = ~mclk;
    always @(posedge mclk) mrise++;
    always @(posedge ser.bit_clock) brise++;
    always @(rx_frames) begin
        #1;
        got_q.push_back({rx_flag, rx_word});
        mark_q.push_back(mrise);
    end

    aso_serial_out DUT (.CLOCK_I(clk), .RESETN_I(rst_n), .MASTER_CLK_I(mclk),
        .SYNC_I(sync), .POWER_DOWN_N_I(pd_n), .SAMPLE_VALID_I(s_valid),
        .SAMPLE_DATA_I(s_data), .SAMPLE_READY_O(s_ready), .SERIAL_O(ser),
        .SERIAL_N_O(ser_n), .RANGE_ERROR_FLAG_O(flag), .INITIALISED_O(init));
    aso_rx_model rx (.serial_i(ser), .serial_n_i(ser_n), .range_flag_i(flag),
        .word_o(rx_word), .flag_o(rx_flag), .frames_o(rx_frames), .errs_o(rx_errs));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [16:0] clip(input int v);
        if (v > 32767) return {1'b1, 16'h7FFF};
        if (v < -32768) return {1'b1, 16'h8000};
        return {1'b0, 16'(v)};
    endfunction
    function automatic int raw_of(input int i);
        return (i < 7) ? raw_tab[i] : i * 2311 - 20000;
    endfunction
    // Called just after a rising edge; holds valid until the word is taken, for at most 2000 cycles.
    task automatic push(input int v);
        int i;
        s_valid <= 1'b1;
        s_data <= RAW_BITS'(v);
        for (i = 0; i < 2000; i++) begin
            @(posedge clk);
            if (s_ready === 1'b1) break;
        end
        s_valid <= 1'b0;
        exp_q.push_back(clip(v));
    endtask
    task automatic wait_frames(input int n, input int lim);
        for (int i = 0; i < lim && got_q.size() < n; i++) @(posedge clk);
    endtask
    task automatic check_words();
        cmp("frame count", exp_q.size(), got_q.size());
        foreach (exp_q[k]) cmp("word", exp_q[k], (k < got_q.size()) ? got_q[k] : 'x);
        exp_q.delete();
        got_q.delete();
        mark_q.delete();
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        repeat (3) @(posedge clk);
        cmp("ser in reset", 3'h0, ser);
        cmp("ser_n in reset", 3'h7, ser_n);
        cmp("ready in reset", 1'b0, s_ready);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (48) @(posedge mclk);
        cmp("frames before sync", 0, rx_frames);
        cmp("init before sync", 1'b0, init);
    endtask
    task automatic t_sync();
        int mark;
        @(negedge mclk);
        @(posedge clk);
        sync <= 1'b1;
        repeat (2) @(negedge mclk);
        @(posedge clk);
        sync <= 1'b0;
        mark = mrise;
        @(posedge clk);
        push(1234);
        wait_frames(1, 16000);
        cmp("init after sync", 1'b1, init);
        cmp("settle", 1'b1, mark_q.size() > 0 && mark_q[0] - mark >= SETTLE_CONV * 16
            && mark_q[0] - mark <= (SETTLE_CONV + 3) * 16);
        check_words();
    endtask
    task automatic t_fill();
        int n, b0, m0;
        b0 = brise;
        m0 = mrise;
        n = 0;
        @(posedge clk);
        s_valid <= 1'b1;
        s_data <= RAW_BITS'(raw_of(0));
        for (int i = 0; i < 100; i++) begin
            @(posedge clk);
            if (s_ready === 1'b1) begin
                exp_q.push_back(clip(raw_of(n)));
                n++;
                s_data <= RAW_BITS'(raw_of(n));
            end else if (n > 0) break;
        end
        s_valid <= 1'b0;
        cmp("accepted until full", 1'b1, n == 16 || n == 17);
        wait_frames(n, n * 220 + 1000);
        for (int k = 1; k < mark_q.size(); k++) begin
            cmp("spacing", 16, mark_q[k] - mark_q[k-1]);
        end
        cmp("bit clock follows", 1'b1, (brise - b0) - (mrise - m0) inside {-1, 0, 1});
        check_words();
    endtask
    task automatic t_pd();
        int f0;
        f0 = rx_frames;
        @(posedge clk);
        pd_n <= 1'b0;
        repeat (4) @(posedge clk);
        mclk_run = 1'b0;
        repeat (20) @(posedge clk);
        cmp("ready in power-down", 1'b0, s_ready);
        cmp("ser in power-down", 3'h0, ser);
        cmp("frames in power-down", f0, rx_frames);
        pd_n <= 1'b1;
        mclk_run = 1'b1;
        // The reference start-up is shortened to keep the run short; the discard is not.
        repeat (16) @(posedge mclk);
        repeat (1600) @(posedge mclk);
        got_q.delete();
        mark_q.delete();
        @(posedge clk);
        push(-5);
        wait_frames(1, 1500);
        cmp("init kept", 1'b1, init);
        check_words();
    endtask

    initial begin
        t_reset();
        t_sync();
        t_fill();
        t_pd();
        cmp("receiver errors", 0, rx_errs);
        give_verdict();
    end
    initial begin
        #800000;
        n_mismatch++;
        give_verdict();
    end
endmodule
